// [hdl/lpr_pkg.sv]
// Package: constants for the logic probe response unit
package lpr_pkg;
	// Clock
	localparam int CLK_PERIOD_PS = 4000;
	// Timing figures in their own units
	localparam int LEVEL_MIN_NS = 75;
	localparam int INVALID_MIN_NS = 100;
	localparam int HOLD_MS = 250;
	localparam int FREE_RATE_HZ = 1000;
	// Derived cycle counts (least times round up, periods exact)
	localparam int LEVEL_MIN_CYC = (LEVEL_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INVALID_MIN_CYC = (INVALID_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam longint HOLD_CYC_L = (64'(HOLD_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1)
		/ 64'(CLK_PERIOD_PS);
	localparam int HOLD_CYC = int'(HOLD_CYC_L);
	localparam int FREE_CYC = int'(64'd1000000000000 / (64'(FREE_RATE_HZ) * 64'(CLK_PERIOD_PS)));
	// Widths
	localparam int CNT_W = 7;
	localparam int SIG_W = 16;
	localparam int TMR_W = 26;
	// Reset values and signature polynomial
	localparam logic [6:0] CNT_RST = 7'h00;
	localparam logic [15:0] SIG_RST = 16'h0000;
	localparam logic [15:0] SIG_POLY = 16'h1281;
	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_HIST = 8'h0C;
	localparam logic [7:0] OFS_SIG = 8'h10;
	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SEL_BIT = 2;
	localparam int CTRL_CAP_BIT = 3;
	// Sync mode encodings
	typedef enum logic [1:0] {
		LPR_FREE = 2'h0,
		LPR_ADDR = 2'h1,
		LPR_DATA = 2'h2
	} lpr_mode_type;
endpackage : lpr_pkg

// [hdl/lpr_response_unit.sv]
// Module: logic probe response unit with APB register slave
// Function
// - Event counter is seven bits and wraps from 127 back to zero.
// - Capture strobe snapshots the count, then clears the counter.
// - Counter counts in every sync mode, ignoring qualification.
// - Count only on falls from above high threshold, not low/invalid moves.
// - Sticky high, invalid, low flags reported on strobe then cleared.
// - In address or data sync, history samples at end of valid period.
// - In free-run, history samples at a 1 kHz rate.
// - Sampled tip bits compress into a 16-bit CRC signature.
// - Signature updates only in address or data sync, never free-run.
// - Only samples taken in valid periods enter the signature.
// - Strobe reports accumulated signature and restarts accumulation.
// - Scope trigger follows sync: falls near cycle start, rises near end.
// - Green lamp lights only for a low lasting more than 75 ns.
// - Red lamp lights only for a high lasting more than 75 ns.
// - Invalid shows both lamps off; invalid shorter than 100 ns ignored.
// - A lamp once lit stays on at least 0.25 seconds.
// - In sync modes lamps respond to the tip only during sync interval.
// - In sync modes only the counter observes all tip activity; lamps, history and signature are gated by sync.
// - Any mode selection clears count, history and signature.
// - Reset leaves free-run selected.
`timescale 1ns/10ps
module lpr_response_unit #(
	parameter logic [15:0] SIG_POLY = lpr_pkg::SIG_POLY,
	parameter int LEVEL_MIN_CYC = lpr_pkg::LEVEL_MIN_CYC,
	parameter int INVALID_MIN_CYC = lpr_pkg::INVALID_MIN_CYC,
	parameter int HOLD_CYC = lpr_pkg::HOLD_CYC,
	parameter int FREE_CYC = lpr_pkg::FREE_CYC
) (
	input wire logic i_mclk, // Instrument clock, 250 MHz
	input wire logic i_srst, // Synchronous reset, active high
	input wire logic i_tip_high, // Tip above high threshold (pin)
	input wire logic i_tip_low, // Tip below low threshold (pin)
	input wire logic i_sync, // Sync pulse, high in valid period (pin)
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error
	output logic o_scope_trig, // Scope trigger, low during sync
	output logic o_lamp_red, // Red lamp drive
	output logic o_lamp_green // Green lamp drive
);
	// Pin synchronisers
	logic [2:0] pin_s1_reg;
	logic [2:0] pin_s2_reg;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {i_sync, i_tip_low, i_tip_high};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire tip_hi = pin_s2_reg[0];
	wire tip_lo = pin_s2_reg[1];
	wire sync_lv = pin_s2_reg[2];
	wire tip_inv = !tip_hi && !tip_lo;

	logic tip_hi_d_reg;
	logic tip_lo_d_reg;
	logic sync_d_reg;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			tip_hi_d_reg <= 1'b0;
			tip_lo_d_reg <= 1'b0;
			sync_d_reg <= 1'b0;
		end else begin
			tip_hi_d_reg <= tip_hi;
			tip_lo_d_reg <= tip_lo;
			sync_d_reg <= sync_lv;
		end
	end

	// APB decode
	wire apb_acc = i_psel && i_penable && o_pready; // Write acts only at the ready edge
	wire apb_wr = apb_acc && i_pwrite;
	wire hit_ctrl = i_paddr == lpr_pkg::OFS_CTRL;
	wire hit_stat = i_paddr == lpr_pkg::OFS_STATUS;
	wire hit_cnt = i_paddr == lpr_pkg::OFS_COUNT;
	wire hit_hist = i_paddr == lpr_pkg::OFS_HIST;
	wire hit_sig = i_paddr == lpr_pkg::OFS_SIG;
	wire hit_any = hit_ctrl || hit_stat || hit_cnt || hit_hist || hit_sig;
	wire ctrl_wr = apb_wr && hit_ctrl;
	wire mode_sel = ctrl_wr && i_pwdata[lpr_pkg::CTRL_SEL_BIT];
	wire capture = ctrl_wr && i_pwdata[lpr_pkg::CTRL_CAP_BIT];
	wire [1:0] wr_mode = i_pwdata[lpr_pkg::CTRL_MODE_LSB +: 2];
	wire wr_mode_ok = wr_mode == lpr_pkg::LPR_ADDR || wr_mode == lpr_pkg::LPR_DATA;

	lpr_pkg::lpr_mode_type mode_reg;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			mode_reg <= lpr_pkg::LPR_FREE;
		end else if (mode_sel) begin
			mode_reg <= wr_mode_ok ? lpr_pkg::lpr_mode_type'(wr_mode) : lpr_pkg::LPR_FREE;
		end
	end
	wire synced = mode_reg != lpr_pkg::LPR_FREE;
	wire clr_acc = capture || mode_sel;

	// Event counter
	wire fall_evt = tip_hi_d_reg && !tip_hi;
	logic [6:0] count_reg;
	logic [6:0] count_cap_reg;
	always_ff @(posedge i_mclk) begin
		if (i_srst || clr_acc) begin
			count_reg <= lpr_pkg::CNT_RST;
		end else if (fall_evt) begin
			count_reg <= count_reg + 7'h01;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_srst || mode_sel) begin
			count_cap_reg <= lpr_pkg::CNT_RST;
		end else if (capture) begin
			count_cap_reg <= count_reg + {6'h00, fall_evt};
		end
	end

	// Sample points
	logic [25:0] free_tmr_reg;
	wire free_tick = free_tmr_reg == 26'(FREE_CYC - 1);
	always_ff @(posedge i_mclk) begin
		if (i_srst || free_tick) begin
			free_tmr_reg <= 26'h0000000;
		end else begin
			free_tmr_reg <= free_tmr_reg + 26'h0000001;
		end
	end
	wire sync_end = sync_d_reg && !sync_lv;
	wire hist_smp = synced ? sync_end : free_tick;
	wire sig_smp = synced && sync_lv;

	// Level history
	logic [2:0] hist_reg;
	logic [2:0] hist_cap_reg;
	// Synced modes record the last level inside the valid period, never invalid
	wire [2:0] hist_sync = {tip_hi_d_reg, 1'b0, tip_lo_d_reg};
	wire [2:0] hist_free = {tip_hi, tip_inv, tip_lo};
	wire [2:0] hist_new = synced ? hist_sync : hist_free;
	always_ff @(posedge i_mclk) begin
		if (i_srst || clr_acc) begin
			hist_reg <= 3'h0;
		end else if (hist_smp) begin
			hist_reg <= hist_reg | hist_new;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_srst || mode_sel) begin
			hist_cap_reg <= 3'h0;
		end else if (capture) begin
			hist_cap_reg <= hist_reg | (hist_smp ? hist_new : 3'h0);
		end
	end

	// Signature register
	logic [15:0] sig_reg;
	logic [15:0] sig_cap_reg;
	wire fb = sig_reg[15] ^ tip_hi;
	wire [15:0] sig_next = {sig_reg[14:0], 1'b0} ^ (fb ? SIG_POLY : 16'h0000);
	always_ff @(posedge i_mclk) begin
		if (i_srst || clr_acc) begin
			sig_reg <= lpr_pkg::SIG_RST;
		end else if (sig_smp) begin
			sig_reg <= sig_next;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_srst || mode_sel) begin
			sig_cap_reg <= lpr_pkg::SIG_RST;
		end else if (capture) begin
			sig_cap_reg <= sig_smp ? sig_next : sig_reg;
		end
	end

	// Lamp qualification
	wire lamp_win = !synced || sync_lv;
	logic [7:0] lo_run_reg;
	logic [7:0] hi_run_reg;
	logic [7:0] inv_run_reg;
	wire lo_q = lamp_win && tip_lo && lo_run_reg == 8'(LEVEL_MIN_CYC);
	wire hi_q = lamp_win && tip_hi && hi_run_reg == 8'(LEVEL_MIN_CYC);
	wire inv_q = lamp_win && tip_inv && inv_run_reg == 8'(INVALID_MIN_CYC);
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			lo_run_reg <= 8'h00;
			hi_run_reg <= 8'h00;
			inv_run_reg <= 8'h00;
		end else begin
			lo_run_reg <= (lamp_win && tip_lo) ? (lo_q ? lo_run_reg : lo_run_reg + 8'h01) : 8'h00;
			hi_run_reg <= (lamp_win && tip_hi) ? (hi_q ? hi_run_reg : hi_run_reg + 8'h01) : 8'h00;
			inv_run_reg <= (lamp_win && tip_inv) ? (inv_q ? inv_run_reg : inv_run_reg + 8'h01) : 8'h00;
		end
	end

	// Lamp hold timers
	logic [25:0] red_tmr_reg;
	logic [25:0] grn_tmr_reg;
	wire red_busy = red_tmr_reg != 26'h0000000;
	wire grn_busy = grn_tmr_reg != 26'h0000000;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			red_tmr_reg <= 26'h0000000;
			grn_tmr_reg <= 26'h0000000;
		end else begin
			red_tmr_reg <= hi_q ? 26'(HOLD_CYC) : (red_busy ? red_tmr_reg - 26'h0000001 : red_tmr_reg);
			grn_tmr_reg <= lo_q ? 26'(HOLD_CYC) : (grn_busy ? grn_tmr_reg - 26'h0000001 : grn_tmr_reg);
		end
	end
	// Lamps: held on by timer; invalid alone turns a lamp off only after hold
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_lamp_red <= 1'b0;
			o_lamp_green <= 1'b0;
		end else begin
			o_lamp_red <= hi_q || (red_busy && !(inv_q && red_tmr_reg == 26'h0000001));
			o_lamp_green <= lo_q || (grn_busy && !(inv_q && grn_tmr_reg == 26'h0000001));
		end
	end

	// Scope trigger
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_scope_trig <= 1'b1;
		end else begin
			o_scope_trig <= !sync_lv;
		end
	end

	// APB read data and answer
	wire [31:0] rd_mux = hit_ctrl ? {29'h0, 1'b0, 2'(mode_reg)} :
		hit_stat ? {26'h0, o_lamp_red, o_lamp_green, hist_reg, synced} :
		hit_cnt ? {25'h0, count_cap_reg} :
		hit_hist ? {29'h0, hist_cap_reg} :
		hit_sig ? {16'h0, sig_cap_reg} : 32'h00000000;
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_prdata <= 32'h00000000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel && !o_pready;
			o_pslverr <= i_psel && !o_pready && !hit_any;
			o_prdata <= (i_psel && !i_pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Assertions
	AST_WRAP: assert property (@(posedge i_mclk) disable iff (i_srst)
		(count_reg == 7'h7F && fall_evt && !clr_acc) |=> count_reg == 7'h00)
		else $error("counter did not wrap");
	AST_CAPCLR: assert property (@(posedge i_mclk) disable iff (i_srst)
		(capture && !mode_sel) |=> count_reg == 7'h00 && count_cap_reg == $past(count_reg) + 7'($past(fall_evt)))
		else $error("capture wrong");
	AST_NOCNT: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!fall_evt && !clr_acc) |=> $stable(count_reg))
		else $error("count without fall");
	AST_FREESIG: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!synced && !clr_acc) |=> $stable(sig_reg))
		else $error("signature moved in free-run");
	AST_MODECLR: assert property (@(posedge i_mclk) disable iff (i_srst)
		mode_sel |=> count_reg == 7'h00 && hist_reg == 3'h0 && sig_reg == 16'h0000)
		else $error("mode select did not clear");
	AST_HOLD: assert property (@(posedge i_mclk) disable iff (i_srst)
		$rose(o_lamp_red) |=> o_lamp_red [*8])
		else $error("red lamp not held");
	AST_GRNQ: assert property (@(posedge i_mclk) disable iff (i_srst)
		$rose(o_lamp_green) |-> $past(lo_q))
		else $error("green lit without low");
	AST_WIN: assert property (@(posedge i_mclk) disable iff (i_srst)
		(synced && !sync_lv) |-> !hi_q && !lo_q)
		else $error("lamp qualified outside window");
	AST_TRIG: assert property (@(posedge i_mclk) disable iff (i_srst)
		$rose(sync_lv) |=> !o_scope_trig)
		else $error("trigger did not fall");

	AST_CNT_INC: assert property (@(posedge i_mclk) disable iff (i_srst)
		(fall_evt && !clr_acc) |=> count_reg == $past(count_reg) + 7'h01)
		else $error("count did not follow fall");

	AST_MODE_RST: assert property (@(posedge i_mclk)
		i_srst |=> mode_reg == lpr_pkg::LPR_FREE)
		else $error("reset did not select free-run");

	AST_HIST_CLR: assert property (@(posedge i_mclk) disable iff (i_srst)
		clr_acc |=> hist_reg == 3'h0)
		else $error("history not cleared");

	AST_HIST_CAP: assert property (@(posedge i_mclk) disable iff (i_srst)
		(capture && !mode_sel) |=> (hist_cap_reg & $past(hist_reg)) == $past(hist_reg))
		else $error("captured history lost a level");

	AST_HIST_STICKY: assert property (@(posedge i_mclk) disable iff (i_srst)
		!clr_acc |=> (hist_reg & $past(hist_reg)) == $past(hist_reg))
		else $error("history flag dropped without clear");

	AST_HIST_SYNCPT: assert property (@(posedge i_mclk) disable iff (i_srst)
		(synced && !sync_end && !clr_acc) |=> $stable(hist_reg))
		else $error("history moved inside valid period");

	AST_HIST_NOINV: assert property (@(posedge i_mclk) disable iff (i_srst)
		synced |-> !hist_reg[1])
		else $error("invalid recorded in sync mode");

	AST_FREE_PT: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!synced && !free_tick && !clr_acc) |=> $stable(hist_reg))
		else $error("free-run history moved off tick");

	AST_TICK: assert property (@(posedge i_mclk) disable iff (i_srst)
		free_tick |=> free_tmr_reg == 26'h0000000)
		else $error("sample timer did not restart");

	AST_SIG_SHIFT: assert property (@(posedge i_mclk) disable iff (i_srst)
		(sig_smp && !clr_acc) |=> sig_reg == (($past(sig_reg) << 1) ^
		(($past(sig_reg[15]) ^ $past(tip_hi)) ? SIG_POLY : 16'h0000)))
		else $error("signature shift wrong");

	AST_SIG_HOLD: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!sig_smp && !clr_acc) |=> $stable(sig_reg))
		else $error("signature moved outside valid period");

	AST_SIG_CAP: assert property (@(posedge i_mclk) disable iff (i_srst)
		(capture && !mode_sel && !sig_smp) |=> sig_cap_reg == $past(sig_reg) && sig_reg == 16'h0000)
		else $error("signature capture wrong");

	AST_TRIG_RISE: assert property (@(posedge i_mclk) disable iff (i_srst)
		$fell(sync_lv) |=> o_scope_trig)
		else $error("trigger did not rise");

	AST_REDQ: assert property (@(posedge i_mclk) disable iff (i_srst)
		$rose(o_lamp_red) |-> $past(hi_q))
		else $error("red lit without high");

	AST_RED_MIN: assert property (@(posedge i_mclk) disable iff (i_srst)
		$rose(hi_q) |-> $past(tip_hi) && $past(hi_run_reg) == 8'(LEVEL_MIN_CYC - 1))
		else $error("high qualified too soon");

	AST_GRN_HOLD: assert property (@(posedge i_mclk) disable iff (i_srst)
		$rose(o_lamp_green) |=> o_lamp_green [*8])
		else $error("green lamp not held");

	AST_RED_TMR: assert property (@(posedge i_mclk) disable iff (i_srst)
		(red_busy && red_tmr_reg != 26'h0000001) |=> o_lamp_red)
		else $error("red dropped during hold");

	AST_GRN_TMR: assert property (@(posedge i_mclk) disable iff (i_srst)
		(grn_busy && grn_tmr_reg != 26'h0000001) |=> o_lamp_green)
		else $error("green dropped during hold");

	AST_LOAD: assert property (@(posedge i_mclk) disable iff (i_srst)
		hi_q |=> red_tmr_reg == 26'(HOLD_CYC))
		else $error("hold timer not loaded");

	AST_RED_OFF: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!hi_q && !red_busy) |=> !o_lamp_red)
		else $error("red lit with no high");

	AST_GRN_OFF: assert property (@(posedge i_mclk) disable iff (i_srst)
		(!lo_q && !grn_busy) |=> !o_lamp_green)
		else $error("green lit with no low");

	AST_WIN_CLR: assert property (@(posedge i_mclk) disable iff (i_srst)
		(synced && !sync_lv) |=> lo_run_reg == 8'h00 && hi_run_reg == 8'h00)
		else $error("level filter ran outside window");
	COV_WRAP: cover property (@(posedge i_mclk) count_reg == 7'h7F && fall_evt);
	COV_CAP: cover property (@(posedge i_mclk) capture && count_reg != 7'h00);
	COV_SIG: cover property (@(posedge i_mclk) capture && synced && sig_reg != 16'h0000);
	COV_BOTH: cover property (@(posedge i_mclk) o_lamp_red && o_lamp_green);
endmodule // lpr_response_unit

// [bench/lpr_target_board.sv]
// Target board model: drives the probe tip bands and the bus sync pulse
`timescale 1ns/10ps
module lpr_target_board (
	input wire logic i_mclk, // Instrument clock
	output logic o_tip_high, // Tip above high threshold
	output logic o_tip_low, // Tip below low threshold
	output logic o_sync // Valid period on the target bus
);
	initial begin
		o_tip_high = 1'b0;
		o_tip_low = 1'b1;
		o_sync = 1'b0;
	end
	// Hold one tip band and sync level for n cycles
	task automatic drive(input logic [1:0] lvl, input logic s, input int n);
		@(posedge i_mclk);
		{o_tip_high, o_tip_low} <= lvl;
		o_sync <= s;
		repeat (n - 1) @(posedge i_mclk);
	endtask
endmodule // lpr_target_board

// [bench/testbench.sv]
// Self-checking testbench for the logic probe response unit
`timescale 1ns/10ps
module testbench;
	localparam logic [1:0] HI = 2'h2, LO = 2'h1, INV = 2'h0;
	localparam logic [7:0] PAT = 8'hB4;
	logic i_mclk, i_srst, psel, penable, pwrite, pready, pslverr, trig, red, green, th, tl, sy, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] exp_sig;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	lpr_target_board tb_u (.i_mclk(i_mclk), .o_tip_high(th), .o_tip_low(tl), .o_sync(sy));
	lpr_response_unit #(.HOLD_CYC(50), .FREE_CYC(20)) dut_u (.i_mclk(i_mclk), .i_srst(i_srst),
		.i_tip_high(th), .i_tip_low(tl), .i_sync(sy), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_scope_trig(trig), .o_lamp_red(red), .o_lamp_green(green));
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	task automatic end_sim();
		$display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_mclk);
		penable <= 1'b1;
		do begin
			@(posedge i_mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ctrl(input logic [1:0] m, input logic s, input logic c);
		apb(1'b1, lpr_pkg::OFS_CTRL, {28'h0000000, c, s, m});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask
	task automatic edges(input int n);
		repeat (n) begin
			tb_u.drive(HI, 1'b0, 3);
			tb_u.drive(LO, 1'b0, 3);
		end
	endtask
	// One valid period of PAT, with unrelated tip moves around it
	task automatic frame();
		tb_u.drive(HI, 1'b0, 3);
		tb_u.drive(LO, 1'b0, 3);
		exp_sig = 16'h0000;
		for (int i = 7; i >= 0; i--) begin
			tb_u.drive(PAT[i] ? HI : LO, 1'b1, 1);
			exp_sig = {exp_sig[14:0], 1'b0} ^ ((exp_sig[15] ^ PAT[i]) ? lpr_pkg::SIG_POLY : 16'h0000);
		end
		tb_u.drive(PAT[0] ? HI : LO, 1'b0, 4);
		tb_u.drive(HI, 1'b0, 6);
	endtask
	task automatic lamp_case(input logic k);
		tb_u.drive(k ? HI : LO, 1'b0, 10);
		tb_u.drive(INV, 1'b0, 30);
		chk({red, green}, 2'h0);
		tb_u.drive(k ? HI : LO, 1'b0, 30);
		chk({red, green}, k ? 2'h2 : 2'h1);
		tb_u.drive(INV, 1'b0, 20);
		chk({red, green}, k ? 2'h2 : 2'h1);
		tb_u.drive(INV, 1'b0, 80);
		chk({red, green}, 2'h0);
	endtask
	initial begin
		i_srst = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (3) @(posedge i_mclk);
		i_srst <= 1'b0;
		rdchk(lpr_pkg::OFS_CTRL, 32'h00000000);
		rdchk(8'h14, 32'h00000000);
		chk(err, 1'b1);
		// Wrap, low-invalid moves and mode-independent counting
		ctrl(2'h0, 1'b1, 1'b0);
		repeat (10) begin
			tb_u.drive(INV, 1'b0, 3);
			tb_u.drive(LO, 1'b0, 3);
		end
		edges(130);
		ctrl(2'h0, 1'b0, 1'b1);
		rdchk(lpr_pkg::OFS_COUNT, 32'h00000002);
		ctrl(2'h1, 1'b1, 1'b0);
		edges(5);
		ctrl(2'h1, 1'b0, 1'b1);
		rdchk(lpr_pkg::OFS_COUNT, 32'h00000005);
		edges(3);
		ctrl(2'h1, 1'b1, 1'b0);
		ctrl(2'h1, 1'b0, 1'b1);
		rdchk(lpr_pkg::OFS_COUNT, 32'h00000000);
		// Free-run history
		ctrl(2'h0, 1'b1, 1'b0);
		tb_u.drive(HI, 1'b0, 30);
		ctrl(2'h0, 1'b1, 1'b0);
		tb_u.drive(HI, 1'b0, 30);
		ctrl(2'h0, 1'b0, 1'b1);
		rdchk(lpr_pkg::OFS_HIST, 32'h00000004);
		tb_u.drive(INV, 1'b0, 30);
		// Flush ticks that still saw the high level
		ctrl(2'h0, 1'b0, 1'b1);
		tb_u.drive(INV, 1'b0, 30);
		ctrl(2'h0, 1'b0, 1'b1);
		rdchk(lpr_pkg::OFS_HIST, 32'h00000002);
		// Signature in address sync, then none in free-run
		ctrl(2'h1, 1'b1, 1'b0);
		ctrl(2'h1, 1'b0, 1'b1);
		frame();
		ctrl(2'h1, 1'b0, 1'b1);
		rdchk(lpr_pkg::OFS_SIG, {16'h0000, exp_sig});
		rdchk(lpr_pkg::OFS_HIST, 32'h00000001);
		ctrl(2'h0, 1'b1, 1'b0);
		frame();
		ctrl(2'h0, 1'b0, 1'b1);
		rdchk(lpr_pkg::OFS_SIG, 32'h00000000);
		// Lamps in free-run, gating and trigger in data sync
		tb_u.drive(INV, 1'b0, 80);
		lamp_case(1'b1);
		lamp_case(1'b0);
		ctrl(2'h2, 1'b1, 1'b0);
		tb_u.drive(HI, 1'b0, 40);
		chk({red, green}, 2'h0);
		tb_u.drive(HI, 1'b1, 30);
		chk({red, trig}, 2'h2);
		tb_u.drive(HI, 1'b0, 6);
		chk(trig, 1'b1);
		rdchk(lpr_pkg::OFS_STATUS, 32'h00000029);
		end_sim();
	end
endmodule // testbench
